// ---- cfe_eng_if.sv ----
`timescale 1ns/1ps
interface cfe_eng_if;
  logic                     tick;
  logic [3:0]               members;
  logic [3:0]               ready;
  logic [3:0]               last;
  logic                     rr_en;
  logic                     swr;
  cfe_pkg::cfe_sync_type    mode;
  logic [3:0]               grant;
  logic                     in_sync;
  logic                     fail_evt;
  modport ctl (output tick, members, ready, last, rr_en, swr, mode,
               input grant, in_sync, fail_evt);
  modport eng (input tick, members, ready, last, rr_en, swr, mode,
               output grant, in_sync, fail_evt);
endinterface

// ---- cfe_engine.sv ----
`timescale 1ns/1ps
module cfe_engine (
  input wire logic clk,
  input wire logic srst,
  cfe_eng_if.eng   e
);
  logic [3:0] grant_r;
  logic [3:0] grant_nxt;
  logic [1:0] rr_ptr_r;
  logic [1:0] rr_ptr_nxt;
  logic       in_sync_r;
  logic       fail_r;
  logic       frame_ok_r;

  wire [3:0] want     = e.ready & e.members;
  wire [3:0] mem_last = e.last & e.members;
  wire       sync_on  = e.mode != cfe_pkg::SYNC_OFF;
  wire       all_rdy  = (e.members != 4'h0) && (want == e.members);
  wire       swr_on   = e.swr && (e.mode != cfe_pkg::SYNC_CONCAT);
  wire       agree    = (mem_last == 4'h0) || (mem_last == e.members);
  wire       sync_go  = e.tick && sync_on && all_rdy;
  wire       frame_ok = sync_go && agree && (mem_last == e.members);
  wire       fail_nxt = sync_go && frame_ok_r && !agree;

  always_comb begin
    grant_nxt = 4'h0;
    rr_ptr_nxt = rr_ptr_r;
    if (e.tick && sync_on) begin
      // wait for all members unless send-when-ready
      grant_nxt = swr_on ? want : (all_rdy ? e.members : 4'h0);
    end else if (e.tick && e.rr_en) begin
      for (int i = 4; i >= 1; i--) begin
        if (want[2'(rr_ptr_r + 2'(i))]) begin
          grant_nxt = 4'h0;
          grant_nxt[2'(rr_ptr_r + 2'(i))] = 1'b1;
          rr_ptr_nxt = 2'(rr_ptr_r + 2'(i));
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      grant_r <= 4'h0;
      rr_ptr_r <= 2'h0;
      fail_r <= 1'b0;
    end else begin
      grant_r <= grant_nxt;
      rr_ptr_r <= rr_ptr_nxt;
      fail_r <= fail_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !sync_on) begin
      // in-sync held low when sync off
      in_sync_r <= 1'b0;
      frame_ok_r <= 1'b0;
    end else begin
      frame_ok_r <= frame_ok_r | frame_ok;
      in_sync_r <= in_sync_r ? !fail_nxt : (sync_go && agree);
    end
  end

  assign e.grant    = grant_r;
  assign e.in_sync  = in_sync_r;
  assign e.fail_evt = fail_r;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  AST_SYNC_WAIT: assert property (
    e.tick && sync_on && !swr_on && !all_rdy |=> grant_r == 4'h0)
    else $error("sync line sent before all ports ready");
  AST_SEND_READY: assert property (
    e.tick && sync_on && swr_on |=> grant_r == $past(want))
    else $error("ready line not sent at once");
  AST_CONCAT_WAIT: assert property (
    e.tick && e.mode == cfe_pkg::SYNC_CONCAT && !all_rdy |=> grant_r == 4'h0)
    else $error("concatenation mode did not wait");
  AST_ROUND_ROBIN: assert property (
    e.tick && !sync_on && e.rr_en && want != 4'h0
      |=> $onehot(grant_r) && (grant_r & $past(want)) != 4'h0)
    else $error("round robin grant wrong");
  AST_MEMBERS_ONLY: assert property (
    ##1 (grant_r & ~$past(e.members)) == 4'h0)
    else $error("grant to unmapped port");
  AST_FAIL_AFTER_OK: assert property (
    $rose(fail_r) |-> $past(frame_ok_r))
    else $error("sync lost before a good frame");
  AST_SYNC_OFF_ZERO: assert property (
    !sync_on |=> !in_sync_r)
    else $error("in-sync set while sync disabled");
endmodule

// ---- cfe_pkg.sv ----
// Notes on behaviour
// - replicate copies output 0 onto output 1
// - synchronized mode waits for all member lines
// - send-when-ready forwards each line when available
// - send-when-ready ignored in concatenation mode
// - one send-when-ready bit serves both outputs
// - output 1 two-bit synchronized mode select
// - output 0 two-bit synchronized mode select
// - round-robin serves ready ports in rotation
// - sync lost only after good frame
// - reading sync lost flag clears it
// - in-sync bit shows synchronized delivery now
// - in-sync reads zero when sync disabled
// - per-port forward off bits, reset one
// - per-port output select bit
package cfe_pkg;
  localparam int NUM_RX = 4;

  localparam logic [7:0] IDX_PORT_CTL = 8'h20;
  localparam logic [7:0] IDX_MODE     = 8'h21;
  localparam logic [7:0] IDX_STS      = 8'h22;
  localparam logic [7:0] IDX_INT_STS  = 8'h28;
  localparam logic [7:0] IDX_INT_MASK = 8'h29;

  localparam logic [7:0] RST_PORT_CTL = 8'hf0;
  localparam logic [7:0] RST_MODE     = 8'h03;
  localparam logic [1:0] RST_LOST     = 2'h0;
  localparam logic [3:0] RST_INT      = 4'h0;

  localparam int PC_OFF_LSB   = 4;
  localparam int PC_SEL_LSB   = 0;
  localparam int MODE_REP_BIT = 7;
  localparam int MODE_SWR_BIT = 6;
  localparam int MODE_S1_LSB  = 4;
  localparam int MODE_S0_LSB  = 2;
  localparam int MODE_RR1_BIT = 1;
  localparam int MODE_RR0_BIT = 0;
  localparam int STS_LOST_LSB = 2;
  localparam int STS_SYNC_LSB = 0;

  typedef enum logic [1:0] {
    SYNC_OFF        = 2'h0,
    SYNC_BASIC      = 2'h1,
    SYNC_INTERLEAVE = 2'h2,
    SYNC_CONCAT     = 2'h3
  } cfe_sync_type;

  function automatic logic [7:0] reg_addr(input logic [7:0] idx);
    reg_addr = {idx[5:0], 2'h0};
  endfunction
endpackage

// ---- cfe_rx_model.sv ----
`timescale 1ns/1ps
// receive-port stand-in: a loaded line waits until the block takes it
module cfe_rx_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       run,
  input  wire logic       load,
  input  wire logic [3:0] load_rdy,
  input  wire logic [3:0] load_last,
  input  wire logic [3:0] take,
  output logic            link_clk,
  output logic      [3:0] rx_line_rdy,
  output logic      [3:0] rx_line_last
);
  logic [3:0] rdy_r;
  logic [3:0] last_r;
  logic       lclk_r = 1'b0;

  // link clock toggles only while traffic runs, else rests low
  always #40 lclk_r = run ? ~lclk_r : 1'b0;
  assign link_clk = lclk_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      rdy_r  <= 4'h0;
      last_r <= 4'h0;
    end else if (load) begin
      rdy_r  <= (rdy_r & ~take) | load_rdy;
      last_r <= load_last;
    end else begin
      rdy_r  <= rdy_r & ~take;
    end
  end

  // no line waiting: last flag shows the inverse, not a stale value
  assign rx_line_rdy  = rdy_r;
  assign rx_line_last = ~(rdy_r ^ last_r);
endmodule

// ---- cfe_top.sv ----
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
module cfe_top (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        link_clk,
  input  wire logic [3:0]  rx_line_rdy,
  input  wire logic [3:0]  rx_line_last,
  output logic      [3:0]  out0_port_grant,
  output logic      [3:0]  out1_port_grant,
  output logic      [3:0]  rx_line_take,
  output logic             irq
);
  logic [7:0]  port_ctl_r;
  logic [7:0]  mode_r;
  logic [1:0]  lost_r;
  logic [1:0]  lost_nxt;
  logic [3:0]  int_sts_r;
  logic [3:0]  int_sts_nxt;
  logic [3:0]  int_mask_r;
  logic        ack_r;
  logic [31:0] readdata_r;
  logic [3:0]  out0_grant_r;
  logic [3:0]  out1_grant_r;
  logic [1:0]  in_sync_d_r;

  logic [2:0]  lclk_sync_r;
  logic [3:0]  rdy_meta_r;
  logic [3:0]  rdy_sync_r;
  logic [3:0]  last_meta_r;
  logic [3:0]  last_sync_r;

  cfe_eng_if e0 ();
  cfe_eng_if e1 ();

  // link clock through three flip-flops, port levels through two each
  always_ff @(posedge clk) begin
    if (srst) begin
      lclk_sync_r <= 3'h0;
      rdy_meta_r <= 4'h0;
      rdy_sync_r <= 4'h0;
      last_meta_r <= 4'h0;
      last_sync_r <= 4'h0;
    end else begin
      lclk_sync_r <= {lclk_sync_r[1:0], link_clk};
      rdy_meta_r <= rx_line_rdy;
      rdy_sync_r <= rdy_meta_r;
      last_meta_r <= rx_line_last;
      last_sync_r <= last_meta_r;
    end
  end

  wire link_tick = lclk_sync_r[1] && !lclk_sync_r[2];

  localparam int PC_OFF_MSB = cfe_pkg::PC_OFF_LSB + 3;
  localparam int PC_SEL_MSB = cfe_pkg::PC_SEL_LSB + 3;

  wire [3:0] fwd_off = port_ctl_r[PC_OFF_MSB:cfe_pkg::PC_OFF_LSB];
  wire [3:0] out_sel = port_ctl_r[PC_SEL_MSB:cfe_pkg::PC_SEL_LSB];
  wire       replicate = mode_r[cfe_pkg::MODE_REP_BIT];
  wire       swr = mode_r[cfe_pkg::MODE_SWR_BIT];
  wire [1:0] sync1_sel = mode_r[cfe_pkg::MODE_S1_LSB +: 2];
  wire [1:0] sync0_sel = mode_r[cfe_pkg::MODE_S0_LSB +: 2];

  wire [3:0] members0 = ~fwd_off & ~out_sel;
  // replicated output engine given no ports
  wire [3:0] members1 = replicate ? 4'h0 : (~fwd_off & out_sel);

  assign e0.tick    = link_tick;
  assign e0.members = members0;
  assign e0.ready   = rdy_sync_r;
  assign e0.last    = last_sync_r;
  assign e0.rr_en   = mode_r[cfe_pkg::MODE_RR0_BIT];
  // one send-when-ready bit for both engines
  assign e0.swr     = swr;
  assign e0.mode    = cfe_pkg::cfe_sync_type'(sync0_sel);

  assign e1.tick    = link_tick;
  assign e1.members = members1;
  assign e1.ready   = rdy_sync_r;
  assign e1.last    = last_sync_r;
  assign e1.rr_en   = mode_r[cfe_pkg::MODE_RR1_BIT];
  assign e1.swr     = swr;
  assign e1.mode    = cfe_pkg::cfe_sync_type'(sync1_sel);

  cfe_engine u_eng0 (
    .clk  (clk),
    .srst (srst),
    .e    (e0.eng)
  );

  cfe_engine u_eng1 (
    .clk  (clk),
    .srst (srst),
    .e    (e1.eng)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      out0_grant_r <= 4'h0;
      out1_grant_r <= 4'h0;
    end else begin
      out0_grant_r <= e0.grant;
      out1_grant_r <= replicate ? e0.grant : e1.grant;
    end
  end

  assign out0_port_grant = out0_grant_r;
  assign out1_port_grant = out1_grant_r;
  assign rx_line_take    = out0_grant_r | (replicate ? 4'h0 : out1_grant_r);

  // bus decode
  wire req      = avs_read || avs_write;
  wire capture  = req && !ack_r;
  wire wr_do    = avs_write && ack_r && avs_byteenable[0];
  wire hit_pc   = avs_address == cfe_pkg::reg_addr(cfe_pkg::IDX_PORT_CTL);
  wire hit_mode = avs_address == cfe_pkg::reg_addr(cfe_pkg::IDX_MODE);
  wire hit_sts  = avs_address == cfe_pkg::reg_addr(cfe_pkg::IDX_STS);
  wire hit_is   = avs_address == cfe_pkg::reg_addr(cfe_pkg::IDX_INT_STS);
  wire hit_im   = avs_address == cfe_pkg::reg_addr(cfe_pkg::IDX_INT_MASK);
  wire sts_rd   = avs_read && capture && hit_sts;

  wire [1:0] in_sync = {e1.in_sync, e0.in_sync};
  wire [1:0] fail_ev = {e1.fail_evt, e0.fail_evt};
  wire [1:0] sync_up = in_sync & ~in_sync_d_r;
  wire [7:0] sts_val = {4'h0, lost_r, in_sync};

  wire [7:0] rd_mux =
    hit_pc   ? port_ctl_r :
    hit_mode ? mode_r :
    hit_sts  ? sts_val :
    hit_is   ? {4'h0, int_sts_r} :
    hit_im   ? {4'h0, int_mask_r} : 8'h00;

  assign avs_waitrequest = req && !ack_r;
  assign avs_readdata    = readdata_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_r <= 1'b0;
      readdata_r <= 32'h0;
    end else begin
      ack_r <= capture;
      if (avs_read && capture) begin
        readdata_r <= {24'h0, rd_mux};
      end
    end
  end

  // read clears sync lost, new event wins
  always_comb begin
    lost_nxt = lost_r;
    if (sts_rd) begin
      lost_nxt = 2'h0;
    end
    lost_nxt = lost_nxt | fail_ev;
  end

  always_comb begin
    int_sts_nxt = int_sts_r;
    if (wr_do && hit_is) begin
      int_sts_nxt = int_sts_r & ~avs_writedata[3:0];
    end
    int_sts_nxt = int_sts_nxt | {sync_up, fail_ev};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lost_r <= cfe_pkg::RST_LOST;
      int_sts_r <= cfe_pkg::RST_INT;
      in_sync_d_r <= 2'h0;
    end else begin
      lost_r <= lost_nxt;
      int_sts_r <= int_sts_nxt;
      in_sync_d_r <= in_sync;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      port_ctl_r <= cfe_pkg::RST_PORT_CTL;
      mode_r <= cfe_pkg::RST_MODE;
      int_mask_r <= cfe_pkg::RST_INT;
    end else if (wr_do) begin
      if (hit_pc) begin
        port_ctl_r <= avs_writedata[7:0];
      end
      if (hit_mode) begin
        mode_r <= avs_writedata[7:0];
      end
      if (hit_im) begin
        int_mask_r <= avs_writedata[3:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_sts_nxt & int_mask_r);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  AST_REPLICATE: assert property (
    replicate ##1 replicate |-> out1_grant_r == out0_grant_r)
    else $error("output 1 differs from output 0 in replicate");

  AST_REPL_NO_OWN: assert property (
    replicate |=> e1.grant == 4'h0)
    else $error("output 1 engine active while replicating");

  AST_READ_CLEARS: assert property (
    sts_rd && fail_ev == 2'h0 |=> lost_r == 2'h0)
    else $error("sync lost not cleared by read");

  AST_LOST_SET: assert property (
    fail_ev[0] |=> lost_r[0] && int_sts_r[0])
    else $error("sync lost event dropped");

  AST_IN_SYNC_READ: assert property (
    avs_read && capture && hit_sts
      |=> readdata_r[1:0] == $past(in_sync))
    else $error("in-sync bits misread");

  AST_OFF_PORT: assert property (
    ##2 (rx_line_take & $past(fwd_off, 2)) == 4'h0)
    else $error("disabled port forwarded");

  AST_WAIT_ONE: assert property (
    capture |=> !avs_waitrequest)
    else $error("bus answer not after one cycle");

  AST_IRQ_LEVEL: assert property (
    $stable(int_mask_r) |-> irq == ((int_sts_r & int_mask_r) != 4'h0))
    else $error("interrupt level wrong");

  AST_OUT0_MAP: assert property (
    ##2 (out0_grant_r & $past(out_sel, 2)) == 4'h0)
    else $error("output 0 granted a port mapped to output 1");

  AST_OUT1_MAP: assert property (
    ##2 $past(replicate) || (out1_grant_r & ~$past(out_sel, 2)) == 4'h0)
    else $error("output 1 granted a port mapped to output 0");

  AST_SYNC0_OFF: assert property (
    sync0_sel == 2'h0 |=> !in_sync[0])
    else $error("output 0 in-sync set while sync disabled");

  AST_SYNC1_OFF: assert property (
    sync1_sel == 2'h0 |=> !in_sync[1])
    else $error("output 1 in-sync set while sync disabled");

  AST_RESET_CTL: assert property (
    $fell(srst) |-> mode_r == cfe_pkg::RST_MODE
      && port_ctl_r == cfe_pkg::RST_PORT_CTL)
    else $error("control registers not at reset value");

  AST_BE_IGNORED: assert property (
    avs_write && ack_r && !avs_byteenable[0]
      |=> $stable(mode_r) && $stable(port_ctl_r) && $stable(int_mask_r))
    else $error("write applied without byte enable");

  AST_LOST_READ: assert property (
    sts_rd |=> readdata_r[3:2] == $past(lost_r))
    else $error("sync lost bits misread");

  AST_SYNC_UP_INT: assert property (
    sync_up[0] |=> int_sts_r[2])
    else $error("in-sync rise not flagged");

  AST_INT_CLEAR: assert property (
    wr_do && hit_is && avs_writedata[0] && !fail_ev[0] |=> !int_sts_r[0])
    else $error("status bit not cleared by write of one");

  AST_UNMAPPED_RD: assert property (
    avs_read && capture && !(hit_pc || hit_mode || hit_sts || hit_is || hit_im)
      |=> readdata_r == 32'h0)
    else $error("unmapped read not zero");

  AST_GRANT0_PULSE: assert property (
    out0_grant_r != 4'h0 |=> out0_grant_r == 4'h0)
    else $error("output 0 grant longer than one cycle");

  AST_GRANT1_PULSE: assert property (
    out1_grant_r != 4'h0 |=> out1_grant_r == 4'h0)
    else $error("output 1 grant longer than one cycle");
endmodule

// ---- cfe_top_test.sv ----
`timescale 1ns/1ps
module cfe_top_test;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        link_clk;
  logic        irq;
  logic        run = 1'b0;
  logic        load = 1'b0;
  logic [3:0]  load_rdy = 4'h0;
  logic [3:0]  load_last = 4'h0;
  logic [3:0]  rdy;
  logic [3:0]  last;
  logic [3:0]  g0;
  logic [3:0]  g1;
  logic [3:0]  take;
  int          error_cnt = 0;
  int          n_checks = 0;

  always #5 clk = ~clk;

  cfe_top u_cfe_top (.clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .link_clk(link_clk), .rx_line_rdy(rdy), .rx_line_last(last),
    .out0_port_grant(g0), .out1_port_grant(g1), .rx_line_take(take),
    .irq(irq));

  cfe_rx_model u_cfe_rx_model (.clk(clk), .srst(srst), .run(run),
    .load(load), .load_rdy(load_rdy), .load_last(load_last), .take(take),
    .link_clk(link_clk), .rx_line_rdy(rdy), .rx_line_last(last));

  task automatic give_verdict();
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d, input logic [3:0] be,
                     output logic [7:0] q);
    avs_address    <= cfe_pkg::reg_addr(idx);
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    avs_read       <= !wr;
    avs_write      <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, 4'h1, q);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] q);
    bus(1'b0, idx, 8'h00, 4'hf, q);
  endtask

  task automatic ld(input logic [3:0] r, input logic [3:0] l);
    load      <= 1'b1;
    load_rdy  <= r;
    load_last <= l;
    @(posedge clk);
    load <= 1'b0;
  endtask

  // run n link periods, gather grants {out1,out0}, replica and output 0 multi-grant flags
  task automatic ticks(input int n, output logic [7:0] g,
                       output logic rep_bad, output logic multi);
    g = 8'h00;
    rep_bad = 1'b0;
    multi = 1'b0;
    run <= 1'b1;
    for (int i = 0; i < n * 8 + 16; i++) begin
      if (i == n * 8) @(posedge clk) run <= 1'b0;
      @(negedge clk);
      g = g | {g1, g0};
      if (g1 !== g0) rep_bad = 1'b1;
      if ($countones(g0) > 1) multi = 1'b1;
    end
    @(posedge clk);
  endtask

  task automatic chk_irq(input logic e);
    repeat (2) @(negedge clk);
    chk({7'h0, irq}, {7'h0, e});
    @(posedge clk);
  endtask

  task automatic t_regs();
    logic [7:0] q;
    rd(8'h21, q); chk(q, 8'h03);
    rd(8'h20, q); chk(q, 8'hf0);
    rd(8'h22, q); chk(q, 8'h00);
    rd(8'h30, q); chk(q, 8'h00);
    bus(1'b1, 8'h21, 8'hff, 4'h0, q);
    rd(8'h21, q); chk(q, 8'h03);
    wr(8'h22, 8'hff);
    rd(8'h22, q); chk(q, 8'h00);
    rd(8'h29, q); chk(q, 8'h00);
  endtask

  task automatic t_rr();
    logic [7:0] g;
    logic rb;
    logic mu;
    ld(4'hf, 4'h0);
    ticks(6, g, rb, mu); chk(g, 8'h00);
    wr(8'h20, 8'h02);
    ticks(6, g, rb, mu); chk(g, 8'h2d);
    chk({7'h0, mu}, 8'h00);
  endtask

  task automatic t_sync();
    logic [7:0] g;
    logic [3:0] e;
    logic rb;
    logic mu;
    for (int o = 0; o < 2; o++) for (int s = 0; s < 2; s++)
      for (int m = 1; m < 4; m++) begin
        // remap only while off, one mode per output
        wr(8'h20, 8'hf0);
        wr(8'h21, {1'b0, 1'(s), o ? 2'(m) : 2'h0, o ? 2'h0 : 2'(m),
                   1'(!o), 1'(o)});
        wr(8'h20, o ? 8'hc3 : 8'hc0);
        ld(4'h1, 4'h0);
        ticks(4, g, rb, mu);
        e = (s == 1 && m != 3) ? 4'h1 : 4'h0;
        chk(g, o ? {e, 4'h0} : {4'h0, e});
        ld(4'h2, 4'h0);
        ticks(4, g, rb, mu);
        e = (s == 1 && m != 3) ? 4'h2 : 4'h3;
        chk(g, o ? {e, 4'h0} : {4'h0, e});
      end
  endtask

  task automatic t_fail();
    logic [7:0] q;
    logic [7:0] g;
    logic rb;
    logic mu;
    wr(8'h20, 8'hf0);
    wr(8'h21, 8'h06);
    wr(8'h20, 8'hc0);
    wr(8'h29, 8'h01);
    ld(4'h3, 4'h1); ticks(3, g, rb, mu);
    rd(8'h22, q); chk(q & 8'h0c, 8'h00);
    ld(4'h3, 4'h3); ticks(3, g, rb, mu);
    rd(8'h22, q); chk(q & 8'h0f, 8'h01);
    ld(4'h3, 4'h1); ticks(3, g, rb, mu);
    rd(8'h22, q); chk(q & 8'h0c, 8'h04);
    rd(8'h22, q); chk(q & 8'h0c, 8'h00);
    chk_irq(1'b1);
    wr(8'h29, 8'h00); chk_irq(1'b0);
    wr(8'h29, 8'h01); chk_irq(1'b1);
    wr(8'h28, 8'h01); chk_irq(1'b0);
    wr(8'h21, 8'h03);
    rd(8'h22, q); chk(q & 8'h03, 8'h00);
  endtask

  task automatic t_rep();
    logic [7:0] g;
    logic rb;
    logic mu;
    wr(8'h20, 8'hf0);
    wr(8'h21, 8'h83);
    wr(8'h20, 8'h00);
    ld(4'hf, 4'h0);
    ticks(6, g, rb, mu); chk(g, 8'hff);
    chk({7'h0, rb}, 8'h00);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_rr();
    t_sync();
    t_fail();
    t_rep();
    give_verdict();
  end

  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
endmodule
